// *** shared/udc_pkg.sv ***
// Constants for the loadable up/down counter and its register window.
// Assumes a 32-bit register port with word-aligned byte addresses.
package udc_pkg;

  localparam int unsigned UDC_CNT_W_DEF = 8;
  localparam int unsigned UDC_ADDR_W = 4;
  localparam int unsigned UDC_DATA_W = 32;

  // Register byte offsets
  localparam logic [UDC_ADDR_W-1:0] UDC_OFF_STATUS = 4'h0;
  localparam logic [UDC_ADDR_W-1:0] UDC_OFF_MASK = 4'h4;
  localparam logic [UDC_ADDR_W-1:0] UDC_OFF_COUNT = 4'h8;

  // Event bits, same layout in status and mask
  localparam int unsigned UDC_EVT_N = 2;
  localparam int unsigned UDC_EVT_WRAP = 0;
  localparam int unsigned UDC_EVT_LOAD = 1;

  localparam logic [UDC_EVT_N-1:0] UDC_STATUS_RST = 2'h0;
  localparam logic [UDC_EVT_N-1:0] UDC_MASK_RST = 2'h0;
  localparam logic [UDC_DATA_W-1:0] UDC_RD_UNMAPPED = 32'h0000_0000;

endpackage : udc_pkg

// *** hdl/udc_core.sv ***
// Counter datapath: count register with async clear, load, enable and direction.
// Assumes control inputs come from logic on the same clock.
`timescale 1ns/1ps
module udc_core import udc_pkg::*; #(
  parameter int unsigned CNT_W = UDC_CNT_W_DEF,
  parameter bit HAS_CLEAR = 1'b1
) (
  input wire logic clk,
  input wire logic clr_n,
  input wire logic load_n,
  input wire logic cnt_en,
  input wire logic direction_select,
  input wire logic [CNT_W-1:0] data_in,
  output logic [CNT_W-1:0] count,
  output logic term,
  output logic wrap_evt,
  output logic load_evt
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  always_comb begin
    if (!load_n) begin
      count_nxt = data_in;
    end else if (cnt_en) begin
      if (direction_select) begin
        count_nxt = count_r + CNT_W'(1);
      end else begin
        count_nxt = count_r - CNT_W'(1);
      end
    end else begin
      count_nxt = count_r;
    end
  end

  // Setting HAS_CLEAR to 0 removes the async path for a smaller, faster counter
  generate
    if (HAS_CLEAR) begin : g_clear
      always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
          count_r <= '0;
        end else begin
          count_r <= count_nxt;
        end
      end
    end else begin : g_noclear
      always_ff @(posedge clk) begin
        count_r <= count_nxt;
      end
    end
  endgenerate

  assign count = count_r;
  assign term = direction_select ? (&count_r) : ~(|count_r);
  assign wrap_evt = load_n & cnt_en & term;
  assign load_evt = ~load_n;

endmodule : udc_core

// *** hdl/udc_counter.sv ***
// Loadable up/down counter with terminal flag and a small event/interrupt window.
// Assumes control pins driven by same-clock logic; clr_n may be asynchronous.
// Notes on behaviour
// - The width parameter is at least one and sets both data and count buses.
// - Load and counting happen only on the rising clock edge.
// - A low clear input zeros the count at once and overrides load and enable; load and wrap events still set status.
// - Priority is clear, then load, then enable, then direction.
// - With load low at an edge the count takes the data input.
// - With enable low and no load the count holds.
// - Enabled, the count steps up when direction is high, down when low.
// - The terminal flag marks all ones counting up and all zeros counting down.
// - With the clear tied high the clear logic may be left out.
`timescale 1ns/1ps
module udc_counter import udc_pkg::*; #(
  parameter int unsigned CNT_W = UDC_CNT_W_DEF,
  parameter bit HAS_CLEAR = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr_n,
  input wire logic load_n,
  input wire logic cnt_en,
  input wire logic direction_select,
  input wire logic [CNT_W-1:0] data_in,
  output logic [CNT_W-1:0] count,
  output logic term,
  input wire logic [UDC_ADDR_W-1:0] reg_addr,
  input wire logic [UDC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [UDC_DATA_W-1:0] reg_rdata,
  output logic irq
);

  logic [CNT_W-1:0] count_w;
  logic term_w;
  logic wrap_evt;
  logic load_evt;
  logic [UDC_EVT_N-1:0] status_r;
  logic [UDC_EVT_N-1:0] mask_r;
  logic [UDC_EVT_N-1:0] evt;
  logic [UDC_DATA_W-1:0] rd_val;

  // Width of one bit is the smallest legal counter
  if (CNT_W < 1) begin : g_bad_width
    $error("counter width must be at least one");
  end

  udc_core #(
    .CNT_W(CNT_W),
    .HAS_CLEAR(HAS_CLEAR)
  ) u_core (
    .clk(clk),
    .clr_n(clr_n),
    .load_n(load_n),
    .cnt_en(cnt_en),
    .direction_select(direction_select),
    .data_in(data_in),
    .count(count_w),
    .term(term_w),
    .wrap_evt(wrap_evt),
    .load_evt(load_evt)
  );

  // Flag stays a live decode so a direction change shows without a clock
  assign count = count_w;
  assign term = term_w;

  assign evt[UDC_EVT_WRAP] = wrap_evt;
  assign evt[UDC_EVT_LOAD] = load_evt;

  // A new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= UDC_STATUS_RST;
    end else if (reg_wr && reg_addr == UDC_OFF_STATUS) begin
      status_r <= (status_r & ~reg_wdata[UDC_EVT_N-1:0]) | evt;
    end else begin
      status_r <= status_r | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= UDC_MASK_RST;
    end else if (reg_wr && reg_addr == UDC_OFF_MASK) begin
      mask_r <= reg_wdata[UDC_EVT_N-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  always_comb begin
    rd_val = UDC_RD_UNMAPPED;
    case (reg_addr)
      UDC_OFF_STATUS: rd_val = UDC_DATA_W'(status_r);
      UDC_OFF_MASK: rd_val = UDC_DATA_W'(mask_r);
      UDC_OFF_COUNT: rd_val = UDC_DATA_W'(count_w);
      default: rd_val = UDC_RD_UNMAPPED;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= '0;
    end
  end

  a_clear_zeros: assert property (
    @(posedge clk) disable iff (!rst_n)
    (HAS_CLEAR && !clr_n) |-> (count == '0))
    else $error("count not zero while clear held low");

  a_load_takes: assert property (
    @(posedge clk) disable iff (!rst_n || !clr_n)
    !load_n |=> (count == $past(data_in)))
    else $error("load did not take the data input");

  a_load_over_en: assert property (
    @(posedge clk) disable iff (!rst_n || !clr_n)
    (!load_n && cnt_en) |=> (count == $past(data_in)) && status_r[UDC_EVT_LOAD])
    else $error("enable overrode load");

  a_standby_hold: assert property (
    @(posedge clk) disable iff (!rst_n || !clr_n)
    (load_n && !cnt_en) |=> $stable(count))
    else $error("count moved in standby");

  a_step_up: assert property (
    @(posedge clk) disable iff (!rst_n || !clr_n)
    (load_n && cnt_en && direction_select) |=> (count == $past(count) + CNT_W'(1)))
    else $error("count did not step up by one");

  a_step_down: assert property (
    @(posedge clk) disable iff (!rst_n || !clr_n)
    (load_n && cnt_en && !direction_select) |=> (count == $past(count) - CNT_W'(1)))
    else $error("count did not step down by one");

  a_wrap_up_zero: assert property (
    @(posedge clk) disable iff (!rst_n || !clr_n)
    (load_n && cnt_en && direction_select && (&count)) |=>
      (count == '0) && status_r[UDC_EVT_WRAP] ##1 (irq || !mask_r[UDC_EVT_WRAP]))
    else $error("up wrap did not reach zero or interrupt missing");

  a_term_decode: assert property (
    @(posedge clk) disable iff (!rst_n)
    term == (direction_select ? (&count) : (count == '0)))
    else $error("terminal flag disagrees with count and direction");

  a_irq_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    |(status_r & mask_r) |=> irq)
    else $error("interrupt missing for unmasked status");

  a_read_one_cycle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data outside the answer cycle");

endmodule : udc_counter

// *** bench/udc_ctl_model.sv ***
// Control logic in front of the counter pins.
// Assumes the caller runs in step with clk.
`timescale 1ns/1ps
module udc_ctl_model import udc_pkg::*; #(
  parameter int unsigned CNT_W = 4
) (
  input wire logic clk,
  output logic load_n,
  output logic cnt_en,
  output logic direction_select,
  output logic [CNT_W-1:0] data_in
);
  initial begin
    load_n = 1'b1;
    cnt_en = 1'b0;
    direction_select = 1'b1;
    data_in = '0;
  end
  // One active edge, then idle so no extra step sneaks in
  task automatic put(input logic l, input logic e, input logic u, input logic [CNT_W-1:0] d);
    @(posedge clk);
    load_n <= l;
    cnt_en <= e;
    direction_select <= u;
    data_in <= d;
    @(posedge clk);
    load_n <= 1'b1;
    cnt_en <= 1'b0;
    #1;
  endtask : put
endmodule : udc_ctl_model

// *** bench/tb.sv ***
// Bench for the up/down counter pins and its event window.
// Assumes the control model drives the counter pins.
`timescale 1ns/1ps
module tb import udc_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, clr_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = '0, din, count;
  logic [31:0] reg_wdata = '0, reg_rdata, rd_val;
  logic load_n, cnt_en, dir, term, irq;
  int n_mismatch = 0, num_checks = 0;
  udc_ctl_model #(.CNT_W(4)) udc_ctl_model_inst (.clk(clk), .load_n(load_n),
    .cnt_en(cnt_en), .direction_select(dir), .data_in(din));
  udc_counter #(.CNT_W(4), .HAS_CLEAR(1'b1)) udc_counter_inst (.clk(clk), .rst_n(rst_n),
    .clr_n(clr_n), .load_n(load_n), .cnt_en(cnt_en), .direction_select(dir),
    .data_in(din), .count(count), .term(term), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  always #10 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input logic l, input logic e, input logic u, input logic [3:0] d);
    udc_ctl_model_inst.put(l, e, u, d);
  endtask : op
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic t_count;
    op(1'b0, 1'b1, 1'b0, 4'h5);
    chk("load", 32'h5, count);
    op(1'b1, 1'b1, 1'b1, 4'ha);
    chk("up", 32'h6, count);
    op(1'b1, 1'b1, 1'b0, 4'ha);
    chk("down", 32'h5, count);
    op(1'b1, 1'b0, 1'b1, 4'ha);
    chk("hold", 32'h5, count);
    $display("t_count done");
  endtask : t_count
  task automatic t_wrap;
    op(1'b0, 1'b0, 1'b1, 4'hf);
    chk("term up", 32'h1, term);
    op(1'b1, 1'b1, 1'b1, 4'h0);
    chk("wrap up", 32'h0, count);
    chk("term off", 32'h0, term);
    op(1'b1, 1'b0, 1'b0, 4'h0);
    chk("term down", 32'h1, term);
    op(1'b1, 1'b1, 1'b0, 4'h0);
    chk("wrap down", 32'hf, count);
    $display("t_wrap done");
  endtask : t_wrap
  task automatic t_irq;
    rd(UDC_OFF_MASK);
    chk("mask reset", 32'(UDC_MASK_RST), rd_val);
    chk("irq masked", 32'h0, irq);
    rd(UDC_OFF_STATUS);
    chk("status", 32'(2**UDC_EVT_WRAP + 2**UDC_EVT_LOAD), rd_val);
    wr(UDC_OFF_MASK, 32'(2**UDC_EVT_WRAP));
    repeat (2) @(posedge clk);
    #1 chk("irq on", 32'h1, irq);
    wr(UDC_OFF_STATUS, 32'h3);
    rd(UDC_OFF_STATUS);
    chk("status clr", 32'h0, rd_val);
    chk("irq off", 32'h0, irq);
    rd(UDC_OFF_COUNT);
    chk("count reg", 32'hf, rd_val);
    rd(4'hc);
    chk("unmapped", UDC_RD_UNMAPPED, rd_val);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_clear;
    op(1'b0, 1'b0, 1'b1, 4'h9);
    @(negedge clk);
    clr_n = 1'b0;
    #1 chk("async clr", 32'h0, count);
    op(1'b0, 1'b1, 1'b1, 4'h6);
    chk("clr wins", 32'h0, count);
    clr_n <= 1'b1;
    op(1'b1, 1'b1, 1'b1, 4'h0);
    chk("resume", 32'h1, count);
    $display("t_clear done");
  endtask : t_clear
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    clr_n <= 1'b1;
    t_count();
    t_wrap();
    t_irq();
    t_clear();
    end_of_test();
  end
  // About 55 cycles of work; allow over twenty times that
  initial begin
    #24000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
